// ---- design/ppo_pkg.sv ----
// Package with constants and register map of the pressure pulse output
package ppo_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned RATE_SLOW_HZ    = 5_000;
    localparam int unsigned RATE_FAST_HZ    = 50_000;
    // Half period in clocks, rounded down
    localparam int unsigned HALF_SLOW       = CLK_HZ / (2 * RATE_SLOW_HZ);
    localparam int unsigned HALF_FAST       = CLK_HZ / (2 * RATE_FAST_HZ);
    localparam int unsigned START_DLY_MS    = 1;
    localparam int unsigned START_DLY_CYC   = CLK_HZ / 1000 * START_DLY_MS;
    // Pressure is held in units of 0.001 hPa
    localparam int unsigned MILLI_PER_LOW   = 100;
    localparam int unsigned MILLI_PER_HIGH  = 10;
    localparam int unsigned MILLI_PER_DECI  = 100;

    localparam logic [11:0] CTRL_ADDR       = 12'h000;
    localparam logic [11:0] OFFS_ADDR       = 12'h004;
    localparam logic [11:0] PRES_ADDR       = 12'h008;
    localparam logic [11:0] TEST_ADDR       = 12'h00C;
    localparam logic [11:0] TCORR_ADDR      = 12'h010;
    localparam logic [11:0] TCNT_ADDR       = 12'h014;
    localparam logic [11:0] STAT_ADDR       = 12'h018;
    localparam logic [11:0] TIN_ADDR        = 12'h01C;

    localparam int unsigned CTRL_EN_BIT     = 0;
    localparam int unsigned CTRL_FAST_BIT   = 1;
    localparam int unsigned CTRL_HIGH_BIT   = 2;
    localparam int unsigned TEST_ARG_BIT    = 1;
    localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
    localparam logic [31:0] OFFS_RST        = 32'h0000_0000;
    localparam logic [31:0] PRES_RST        = 32'h0000_0000;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HIGH, ST_LOW} ppo_state_e;
endpackage : ppo_pkg

// ---- design/ppo_divider.sv ----
// Pulse count arithmetic: corrected pressure and rounded quotient
`timescale 1ns/1ns
module ppo_divider
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    input  wire logic        start,
    input  wire logic [31:0] pres_milli,
    input  wire logic [31:0] offs_deci,
    input  wire logic        high_res,
    output logic             busy,
    output logic [31:0]      corr_milli,
    output logic [31:0]      count
);
    import ppo_pkg::*;

    typedef struct packed {
        logic        busy;
        logic [31:0] corr;
        logic [31:0] rem;
        logic [31:0] quo;
        logic [31:0] step;
    } ppo_div_s;

    ppo_div_s s_q;
    ppo_div_s s_d;
    logic signed [63:0] corr_w;

    always_comb
    begin
        s_d    = s_q;
        corr_w = 64'($signed(pres_milli))
               + 64'($signed(offs_deci)) * 64'(MILLI_PER_DECI);
        if (start && !s_q.busy)
        begin
            s_d.busy = 1'b1;
            s_d.corr = corr_w[31:0];
            s_d.step = high_res ? 32'(MILLI_PER_HIGH)
                                : 32'(MILLI_PER_LOW);
            // Negative corrected pressure gives no pulses
            s_d.rem  = corr_w[63] ? 32'h0000_0000
                     : 32'(corr_w[31:0] + (s_d.step >> 1));
            s_d.quo  = 32'h0000_0000;
        end
        else if (s_q.busy)
        begin
            // Repeated subtraction; slow but small, delay is allowed
            if (s_q.rem >= s_q.step)
            begin
                s_d.rem = s_q.rem - s_q.step;
                s_d.quo = s_q.quo + 32'h0000_0001;
            end
            else
                s_d.busy = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            s_q <= '0;
        else if (clk_en)
            s_q <= s_d;
    end

    assign busy       = s_q.busy;
    assign corr_milli = s_q.corr;
    assign count      = s_q.quo;
endmodule : ppo_divider

// ---- design/ppo_top.sv ----
// Pressure pulse output block with APB registers
`timescale 1ns/1ns
//
// Function
// - Burst rate is slow about 5 kHz or fast about 50 kHz.
// - One pulse is 0.1 hPa low resolution or 0.01 hPa high.
// - Count is pressure plus offset over step, rounded to nearest.
// - Offset is signed with one decimal; negative lowers pressure.
// - Enable, rate, resolution, offset are stored independently.
// - Trigger is honoured only while the arm switch is on.
// - Test reports input, corrected pressure and count, any switch.
// - Test with argument uses that pressure instead of measured.
// - No burst starts while in error; error ends a burst only during its start delay.
// - Pulse mode unavailable when analog module is fitted.
// - Burst starts on trigger falling edge.
// - First pulse within 1 to 100 ms of trigger fall.
module ppo_top
#(
    parameter int unsigned START_CYC = ppo_pkg::START_DLY_CYC
)
(
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 clk_en,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    input  wire logic                 trigger_in,
    input  wire logic                 trigger_arm_switch,
    input  wire logic                 error_active,
    input  wire logic                 analog_fitted,
    input  wire logic [31:0]          meas_pressure,
    output logic                      pulse_out
);
    import ppo_pkg::*;

    typedef struct packed {
        logic [2:0]  trg_sync;
        logic [1:0]  arm_sync;
        logic [1:0]  err_sync;
        logic [1:0]  ana_sync;
        logic        trg_prev;
        logic        en;
        logic        fast;
        logic        high;
        logic [31:0] offs;
        logic [31:0] test_pres;
        logic [31:0] test_in;
        logic        test_busy;
        logic        test_done;
        logic        burst_calc;
        ppo_state_e  st;
        logic [31:0] remain;
        logic [31:0] tmr;
        logic        pulse;
        logic [31:0] rdata;
        logic        div_go;
        logic        div_seen;
    } ppo_top_s;

    ppo_top_s    s_q;
    ppo_top_s    s_d;
    logic        div_busy;
    logic [31:0] div_corr;
    logic [31:0] div_count;
    logic [31:0] div_pres;
    logic        wr_acc;
    logic        rd_acc;
    logic        armed;
    logic        err_now;
    logic        trg_fall;
    logic [31:0] half_cyc;

    function automatic logic [31:0] half_period(input logic fast);
        half_period = fast ? 32'(HALF_FAST) : 32'(HALF_SLOW);
    endfunction : half_period

    // Test pressure only when a test runs, otherwise the measured value
    assign div_pres = s_q.test_busy ? s_q.test_in : meas_pressure;

    ppo_divider u_div
    (
        .clock      (clock),
        .nrst       (nrst),
        .clk_en     (clk_en),
        .start      (s_q.div_go),
        .pres_milli (div_pres),
        .offs_deci  (s_q.offs),
        .high_res   (s_q.high),
        .busy       (div_busy),
        .corr_milli (div_corr),
        .count      (div_count)
    );

    assign wr_acc   = psel && penable && pwrite;
    assign rd_acc   = psel && !penable && !pwrite;
    assign err_now  = s_q.err_sync[1];
    always_comb
    begin
        half_cyc = half_period(s_q.fast);
        trg_fall = s_q.trg_prev && !s_q.trg_sync[1];
        // Mode is usable only when enabled, switched on, no analog card
        armed    = s_q.en && s_q.arm_sync[1]
                && !s_q.ana_sync[1];
    end

    always_comb
    begin
        s_d          = s_q;
        s_d.div_go   = 1'b0;
        s_d.trg_sync = {s_q.trg_sync[1:0], trigger_in};
        s_d.arm_sync = {s_q.arm_sync[0], trigger_arm_switch};
        s_d.err_sync = {s_q.err_sync[0], error_active};
        s_d.ana_sync = {s_q.ana_sync[0], analog_fitted};
        s_d.trg_prev = s_q.trg_sync[1];

        if (wr_acc)
        begin
            unique case (paddr)
                CTRL_ADDR:
                begin
                    // Fields kept separately so other settings survive
                    s_d.en   = pwdata[CTRL_EN_BIT];
                    s_d.fast = pwdata[CTRL_FAST_BIT];
                    s_d.high = pwdata[CTRL_HIGH_BIT];
                end
                OFFS_ADDR: s_d.offs = pwdata;
                PRES_ADDR: s_d.test_pres = pwdata;
                TEST_ADDR:
                begin
                    // Test runs regardless of the arm switch
                    if (pwdata[0] && !s_q.test_busy && s_q.st == ST_IDLE)
                    begin
                        s_d.test_busy = 1'b1;
                        s_d.test_done = 1'b0;
                        s_d.test_in   = pwdata[TEST_ARG_BIT]
                                      ? s_q.test_pres : meas_pressure;
                        s_d.div_go    = 1'b1;
                        s_d.div_seen  = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        if (rd_acc)
        begin
            unique case (paddr)
                CTRL_ADDR:  s_d.rdata = {29'h0000_0000, s_q.high,
                                         s_q.fast, s_q.en};
                OFFS_ADDR:  s_d.rdata = s_q.offs;
                PRES_ADDR:  s_d.rdata = s_q.test_pres;
                TEST_ADDR:  s_d.rdata = {30'h0000_0000, s_q.test_done,
                                         s_q.test_busy};
                TIN_ADDR:   s_d.rdata = s_q.test_in;
                TCORR_ADDR: s_d.rdata = div_corr;
                TCNT_ADDR:  s_d.rdata = div_count;
                STAT_ADDR:  s_d.rdata = {26'h000_0000, armed,
                                         s_q.ana_sync[1], err_now,
                                         s_q.arm_sync[1],
                                         s_q.st != ST_IDLE, s_q.pulse};
                default:    s_d.rdata = 32'h0000_0000;
            endcase
        end

        if (div_busy)
            s_d.div_seen = 1'b1;
        if (s_q.test_busy && s_q.div_seen && !div_busy && !s_q.div_go)
        begin
            s_d.test_busy = 1'b0;
            s_d.test_done = 1'b1;
        end

        unique case (s_q.st)
            ST_IDLE:
            begin
                s_d.pulse = 1'b1;
                if (trg_fall && armed && !err_now && !s_q.test_busy)
                begin
                    s_d.st         = ST_WAIT;
                    s_d.div_go     = 1'b1;
                    s_d.div_seen   = 1'b0;
                    s_d.burst_calc = 1'b1;
                    s_d.tmr        = 32'(START_CYC);
                end
            end
            ST_WAIT:
            begin
                // Least delay of 1 ms, then wait for the count
                if (s_q.tmr != 32'h0000_0000)
                    s_d.tmr = s_q.tmr - 32'h0000_0001;
                if (s_q.burst_calc && s_q.div_seen && !div_busy
                    && !s_q.div_go)
                begin
                    s_d.burst_calc = 1'b0;
                    s_d.remain     = div_count;
                end
                if (err_now || !armed)
                    s_d.st = ST_IDLE;
                else if (!s_q.burst_calc && s_q.tmr == 32'h0000_0000)
                begin
                    if (s_q.remain == 32'h0000_0000)
                        s_d.st = ST_IDLE;
                    else
                    begin
                        s_d.st    = ST_LOW;
                        s_d.pulse = 1'b0;
                        s_d.tmr   = half_cyc - 32'h0000_0001;
                    end
                end
            end
            ST_LOW:
            begin
                if (s_q.tmr != 32'h0000_0000)
                    s_d.tmr = s_q.tmr - 32'h0000_0001;
                else
                begin
                    s_d.st     = ST_HIGH;
                    s_d.pulse  = 1'b1;
                    s_d.tmr    = half_cyc - 32'h0000_0001;
                    s_d.remain = s_q.remain - 32'h0000_0001;
                end
            end
            ST_HIGH:
            begin
                if (s_q.tmr != 32'h0000_0000)
                    s_d.tmr = s_q.tmr - 32'h0000_0001;
                else if (s_q.remain == 32'h0000_0000)
                    s_d.st = ST_IDLE;
                else
                begin
                    s_d.st    = ST_LOW;
                    s_d.pulse = 1'b0;
                    s_d.tmr   = half_cyc - 32'h0000_0001;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q          <= '0;
            s_q.trg_sync <= 3'h7;
            s_q.trg_prev <= 1'b1;
            s_q.pulse    <= 1'b1;
            s_q.en       <= CTRL_RST[CTRL_EN_BIT];
            s_q.fast     <= CTRL_RST[CTRL_FAST_BIT];
            s_q.high     <= CTRL_RST[CTRL_HIGH_BIT];
            s_q.offs     <= OFFS_RST;
            s_q.test_pres <= PRES_RST;
            s_q.st       <= ST_IDLE;
        end
        else if (clk_en)
            s_q <= s_d;
    end

    assign pready    = 1'b1;
    assign pslverr   = 1'b0;
    assign prdata    = s_q.rdata;
    assign pulse_out = s_q.pulse;
endmodule : ppo_top

// ---- dv/ppo_chk_sva.sv ----
// Assertion checker on the pulse output block ports
`timescale 1ns/1ns
module ppo_chk
    import ppo_pkg::*;
#(
    parameter int unsigned START_CYC = START_DLY_CYC
)
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        trigger_in,
    input wire logic        analog_fitted,
    input wire logic        pulse_out
);
    localparam logic [31:0] ONE = 32'h0000_0001;
    logic [31:0] lo_q, hi_q, trg_cnt_q, offs_q;
    logic [2:0]  ctrl_q;
    logic        trg_q, seen_q, wr, fast;
    assign wr   = psel && penable && pwrite && pready;
    assign fast = ctrl_q[CTRL_FAST_BIT];

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            {lo_q, hi_q, seen_q} <= '0;
            trg_cnt_q <= '1;
            trg_q     <= 1'b1;
            ctrl_q    <= CTRL_RST[2:0];
            offs_q    <= OFFS_RST;
        end
        else
        begin
            lo_q   <= pulse_out ? '0 : lo_q + ONE;
            hi_q   <= pulse_out ? hi_q + ONE : '0;
            trg_q  <= trigger_in;
            seen_q <= seen_q | (trg_q & ~trigger_in);
            // Saturates so a stale count never wraps into a false failure
            if (trg_q && !trigger_in)
                trg_cnt_q <= '0;
            else if (!(&trg_cnt_q))
                trg_cnt_q <= trg_cnt_q + ONE;
            if (wr && paddr == CTRL_ADDR)
                ctrl_q <= pwdata[2:0];
            if (wr && paddr == OFFS_ADDR)
                offs_q <= pwdata;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    low_width_a: assert property ($rose(pulse_out) |->
        lo_q == (fast ? HALF_FAST : HALF_SLOW))
        else $error("pulse low time wrong");
    high_width_a: assert property ($fell(pulse_out) |->
        hi_q >= (fast ? HALF_FAST : HALF_SLOW))
        else $error("pulse high time too short");
    start_delay_a: assert property ($fell(pulse_out) |->
        trg_cnt_q >= START_CYC)
        else $error("pulse too soon after trigger");
    after_trig_a: assert property ($fell(pulse_out) |-> seen_q)
        else $error("pulse without trigger fall");
    idle_off_a: assert property (!ctrl_q[CTRL_EN_BIT] |-> pulse_out)
        else $error("pulse while disabled");
    no_analog_a: assert property ($fell(pulse_out) |->
        !$past(analog_fitted))
        else $error("pulse with analog module fitted");
    apb_answer_a: assert property (psel && penable |->
        pready && !pslverr)
        else $error("bad bus answer");
    ctrl_read_a: assert property (psel && !penable && !pwrite &&
        paddr == CTRL_ADDR ##1 penable |-> prdata[2:0] == ctrl_q)
        else $error("control read back wrong");
    offs_read_a: assert property (psel && !penable && !pwrite &&
        paddr == OFFS_ADDR ##1 penable |-> prdata == offs_q)
        else $error("offset read back wrong");
endmodule : ppo_chk

// ---- dv/ppo_host_model.sv ----
// Host pulse counter model with trigger output and gate
`timescale 1ns/1ns
module ppo_host_model
#(
    parameter int unsigned TRIG_LEN = 200
)
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        host_start,
    input  wire logic [31:0] gate_cyc,
    input  wire logic        pulse_out,
    output logic             trigger_in,
    output logic [31:0]      host_count,
    output logic             host_done
);
    logic [31:0] tmr_q;
    logic        gate_q, pulse_q;

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            trigger_in <= 1'b1;
            {host_count, host_done, gate_q, tmr_q} <= '0;
            pulse_q    <= 1'b1;
        end
        else
        begin
            pulse_q <= pulse_out;
            if (host_start && !gate_q)
            begin
                host_count <= '0;
                host_done  <= 1'b0;
                gate_q     <= 1'b1;
                tmr_q      <= '0;
            end
            else if (gate_q)
            begin
                tmr_q <= tmr_q + 32'h0000_0001;
                // Negative pulse, well over 1 us low
                trigger_in <= !(tmr_q >= 10 && tmr_q < 10 + TRIG_LEN);
                if (pulse_q && !pulse_out)
                    host_count <= host_count + 32'h0000_0001;
                if (tmr_q == gate_cyc)
                begin
                    gate_q    <= 1'b0;
                    host_done <= 1'b1;
                end
            end
        end
    end
endmodule : ppo_host_model

// ---- dv/tb_top.sv ----
// Top testbench of the pressure pulse output block
`timescale 1ns/1ns
module tb_top;
    import ppo_pkg::*;
    logic        clock, nrst, clk_en, psel, penable, pwrite, pready;
    logic        pslverr, trigger_in, trigger_arm_switch, error_active;
    logic        analog_fitted, pulse_out, host_start, host_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, meas_pressure, gate_cyc, host_count, q;
    int          num_errors, tests_run;
    // Start delay cut so a whole burst fits the run; checker follows it
    localparam int unsigned START_SHORT = 1000;
    localparam logic [31:0] GATE_CYC    =
        32'(START_SHORT + 4 * HALF_FAST + 2000);

    ppo_top #(.START_CYC(START_SHORT)) ppo_top_inst
    (
        .clock              (clock),
        .nrst               (nrst),
        .clk_en             (clk_en),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .prdata             (prdata),
        .trigger_in         (trigger_in),
        .trigger_arm_switch (trigger_arm_switch),
        .error_active       (error_active),
        .analog_fitted      (analog_fitted),
        .meas_pressure      (meas_pressure),
        .pulse_out          (pulse_out)
    );

    ppo_host_model ppo_host_model_inst
    (
        .clock      (clock),
        .nrst       (nrst),
        .host_start (host_start),
        .gate_cyc   (gate_cyc),
        .pulse_out  (pulse_out),
        .trigger_in (trigger_in),
        .host_count (host_count),
        .host_done  (host_done)
    );

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic stop_test;
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic hang;
        num_errors++;
        $display("CHECK FAILED at %0t: wait timed out", $time);
        stop_test();
    endtask : hang

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            hang();
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(q, e);
    endtask : rd

    task automatic run_test(input logic [31:0] cmd);
        int n;
        apb(1'b1, TEST_ADDR, cmd);
        n = 0;
        do
        begin
            apb(1'b0, TEST_ADDR, '0);
            n++;
        end
        while (q[1:0] !== 2'b10 && n < 20000);
        if (q[1:0] !== 2'b10)
            hang();
    endtask : run_test

    task automatic host_run(input logic [31:0] g, input logic [31:0] e);
        int n;
        gate_cyc   <= g;
        host_start <= 1'b1;
        @(posedge clock);
        host_start <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (host_done !== 1'b1 && n < g + 100);
        if (host_done !== 1'b1)
            hang();
        chk(host_count, e);
        chk(32'(pulse_out), 32'h0000_0001);
    endtask : host_run

    initial
    begin
        nrst   = 1'b0;
        clk_en = 1'b1;
        {psel, penable, pwrite, host_start} = '0;
        {trigger_arm_switch, error_active, analog_fitted} = '0;
        {paddr, pwdata, gate_cyc, meas_pressure} = '0;
        num_errors = 0;
        tests_run  = 0;
        repeat (3) @(posedge clock);
        chk(32'(pulse_out), 32'h0000_0001);
        chk(prdata, 32'h0000_0000);
        nrst <= 1'b1;
        @(posedge clock);
        rd(CTRL_ADDR, CTRL_RST);
        rd(OFFS_ADDR, OFFS_RST);
        rd(12'h020, 32'h0000_0000);
        apb(1'b1, CTRL_ADDR, 32'h0000_0007);
        // Offset of -800.0 hPa in tenths
        apb(1'b1, OFFS_ADDR, 32'hFFFF_E0C0);
        apb(1'b1, CTRL_ADDR, 32'h0000_0006);
        rd(CTRL_ADDR, 32'h0000_0006);
        rd(OFFS_ADDR, 32'hFFFF_E0C0);
        // Arm switch still off: test must run regardless
        apb(1'b1, CTRL_ADDR, 32'h0000_0001);
        apb(1'b1, PRES_ADDR, 32'h000F_4240);
        run_test(32'h0000_0003);
        rd(TIN_ADDR, 32'h000F_4240);
        rd(TCORR_ADDR, 32'h0003_0D40);
        rd(TCNT_ADDR, 32'h0000_07D0);
        meas_pressure <= 32'h000F_7602;
        apb(1'b1, OFFS_ADDR, 32'h0000_0000);
        run_test(32'h0000_0001);
        rd(TCORR_ADDR, 32'h000F_7602);
        rd(TCNT_ADDR, 32'h0000_2795);
        meas_pressure <= 32'h0000_00C8;
        for (int i = 0; i < 4; i++)
        begin
            trigger_arm_switch <= (i != 0);
            error_active       <= (i == 1);
            analog_fitted      <= (i == 2);
            apb(1'b1, CTRL_ADDR, (i == 3) ? 32'h0000_0002 : 32'h0000_0003);
            // Gate long enough that a wrongly started burst is counted
            host_run(GATE_CYC, 32'h0000_0000);
        end
        {error_active, analog_fitted} <= '0;
        apb(1'b1, CTRL_ADDR, 32'h0000_0003);
        // Same gate as the blocked cases, 2000 cycles beyond start delay and two fast pulses
        host_run(GATE_CYC, 32'h0000_0002);
        stop_test();
    end
endmodule : tb_top

bind ppo_top ppo_chk #(.START_CYC(START_CYC)) ppo_chk_inst
(
    .clock         (clock),
    .nrst          (nrst),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .prdata        (prdata),
    .trigger_in    (trigger_in),
    .analog_fitted (analog_fitted),
    .pulse_out     (pulse_out)
);
